/* src/tlbm_defs.vh */
`ifndef TLBM_DEFS_VH
`define TLBM_DEFS_VH

// special register number of the replacement hint register
`define TLBM_HINT_REG_NUM   8'h0e

// hint register field layout
`define TLBM_HINT_FIELD_MSB 6
`define TLBM_HINT_FIELD_LSB 1
`define TLBM_HINT_RESET     6'h00

// buffer geometry
`define TLBM_SET_BITS       5
`define TLBM_REG_SEL_BITS   7

// trap vector numbers
`define TLBM_VEC_USER_IMISS  8'h08
`define TLBM_VEC_USER_DMISS  8'h09
`define TLBM_VEC_SUPER_IMISS 8'h0a
`define TLBM_VEC_SUPER_DMISS 8'h0b
`define TLBM_VEC_IPROT       8'h0c
`define TLBM_VEC_DPROT       8'h0d

`endif

/* src/tlbm_buf_store.v */
`timescale 1ns/1ps
`default_nettype none

// translation-buffer word store, one write and one registered read port
module tlbm_buf_store #(
  parameter SEL_BITS  = 7,
  parameter DATA_BITS = 32
) (
  // clock and reset
  input  wire                 i_clock,
  input  wire                 i_rst_n,
  // write port
  input  wire                 i_wr_en,
  input  wire [SEL_BITS-1:0]  i_wr_sel,
  input  wire [DATA_BITS-1:0] i_wr_data,
  // read port
  input  wire                 i_rd_en,
  input  wire [SEL_BITS-1:0]  i_rd_sel,
  output reg  [DATA_BITS-1:0] o_rd_data,
  output reg                  o_rd_done
);

  reg [DATA_BITS-1:0] words [0:(1<<SEL_BITS)-1];

  // contents carry no reset; software loads every entry before use
  always @(posedge i_clock) begin
    if (i_wr_en) begin
      words[i_wr_sel] <= i_wr_data;
    end
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= {DATA_BITS{1'b0}};
      o_rd_done <= 1'b0;
    end else begin
      o_rd_done <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= words[i_rd_sel];
      end
    end
  end

endmodule // tlbm_buf_store

`default_nettype wire

/* src/tlbm_miss_reload.v */
`timescale 1ns/1ps
`default_nettype none
`include "tlbm_defs.vh"

module tlbm_miss_reload #(
  parameter SET_BITS = `TLBM_SET_BITS,
  parameter SEL_BITS = `TLBM_REG_SEL_BITS
) (
  // clock and reset
  input  wire        i_clock,
  input  wire        i_rst_n,
  // translation result from the lookup logic
  input  wire        i_xlat_valid,
  input  wire        i_xlat_instr,
  input  wire        i_xlat_super,
  input  wire        i_xlat_hit,
  input  wire        i_xlat_hit_way,
  input  wire        i_xlat_prot_viol,
  input  wire [4:0]  i_xlat_set,
  input  wire [31:0] i_xlat_addr,
  input  wire        i_xlat_branch_or_newpage,
  // trap outputs
  output reg         o_trap,
  output reg  [7:0]  o_trap_vector,
  output reg         o_pc1_load,
  output reg  [31:0] o_pc1_addr,
  output reg         o_chan_load,
  output reg  [31:0] o_chan_addr,
  // special register read
  input  wire        i_spr_rd,
  input  wire [7:0]  i_spr_num,
  output reg         o_spr_hit,
  output reg  [31:0] o_spr_rdata,
  // buffer moves
  input  wire        i_move_to_xlat_buffer,
  input  wire        i_move_from_xlat_buffer,
  input  wire [31:0] i_move_sel,
  input  wire [31:0] i_move_data,
  output wire [31:0] o_move_rdata,
  output wire        o_move_done,
  // instruction cache control
  input  wire        i_cache_flush_instr,
  input  wire        i_return_and_flush_instr,
  input  wire        i_iret_exec,
  input  wire        i_branch_ok,
  input  wire        i_block_boundary,
  input  wire        i_icache_disable_bit,
  input  wire        i_instr_xlat_en,
  input  wire        i_fetch_super,
  output reg         o_icache_flush_all,
  output reg         o_icache_lookup_virtual,
  output reg         o_icache_force_miss,
  output reg         o_icache_tag_virtual,
  output reg         o_icache_tag_super
);

  //////////////////////////////////////////////////////////////////////////////
  // flush sequencer states

  localparam [2:0] ST_IDLE       = 3'b001;
  localparam [2:0] ST_WAIT_BOUND = 3'b010;
  localparam [2:0] ST_WAIT_IRET  = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg       next_flush;

  //////////////////////////////////////////////////////////////////////////////
  // recency and hint state

  reg [(1<<SET_BITS)-1:0] recency;
  reg [5:0]               replacement_hint;

  wire lookup_miss;
  wire lookup_prot;
  wire lru_way;

  assign lookup_miss = i_xlat_valid & ~i_xlat_hit;
  assign lookup_prot = i_xlat_valid & i_xlat_hit & i_xlat_prot_viol;
  // recency bit names the way that was not used last
  assign lru_way     = recency[i_xlat_set];

  // recency, one bit per two-entry set
  genvar g;
  generate
    for (g = 0; g < (1<<SET_BITS); g = g + 1) begin : g_recency
      always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          recency[g] <= 1'b0;
        end else if (i_xlat_valid && i_xlat_hit && !i_xlat_prot_viol &&
                     i_xlat_set == g) begin
          recency[g] <= ~i_xlat_hit_way;
        end
      end
    end
  endgenerate

  // hint: entry number {way, set}; register number appends word 0
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      replacement_hint <= `TLBM_HINT_RESET;
    end else if (lookup_miss) begin
      replacement_hint <= {lru_way, i_xlat_set};
    end else if (lookup_prot) begin
      // value carries no meaning here but the update still happens
      replacement_hint <= {lru_way, i_xlat_set};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // trap generation; the buffer itself is never written here

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_trap        <= 1'b0;
      o_trap_vector <= 8'h00;
      o_pc1_load    <= 1'b0;
      o_pc1_addr    <= 32'h0000_0000;
      o_chan_load   <= 1'b0;
      o_chan_addr   <= 32'h0000_0000;
    end else begin
      o_trap      <= lookup_miss | lookup_prot;
      o_pc1_load  <= lookup_miss & i_xlat_instr;
      o_chan_load <= lookup_miss & ~i_xlat_instr;
      if (lookup_miss) begin
        case ({i_xlat_super, i_xlat_instr})
          2'b01:   o_trap_vector <= `TLBM_VEC_USER_IMISS;
          2'b00:   o_trap_vector <= `TLBM_VEC_USER_DMISS;
          2'b11:   o_trap_vector <= `TLBM_VEC_SUPER_IMISS;
          default: o_trap_vector <= `TLBM_VEC_SUPER_DMISS;
        endcase
        if (i_xlat_instr) begin
          o_pc1_addr <= i_xlat_addr;
        end else begin
          o_chan_addr <= i_xlat_addr;
        end
      end else if (lookup_prot) begin
        if (i_xlat_instr) begin
          o_trap_vector <= `TLBM_VEC_IPROT;
        end else begin
          o_trap_vector <= `TLBM_VEC_DPROT;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // special register read of the hint

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_spr_hit   <= 1'b0;
      o_spr_rdata <= 32'h0000_0000;
    end else begin
      o_spr_hit <= i_spr_rd && (i_spr_num == `TLBM_HINT_REG_NUM);
      if (i_spr_rd && (i_spr_num == `TLBM_HINT_REG_NUM)) begin
        o_spr_rdata <= {25'h0000000, replacement_hint, 1'b0};
      end else begin
        o_spr_rdata <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // buffer word moves

  tlbm_buf_store #(
    .SEL_BITS  (SEL_BITS),
    .DATA_BITS (32)
  ) u_store (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_wr_en   (i_move_to_xlat_buffer),
    .i_wr_sel  (i_move_sel[SEL_BITS-1:0]),
    .i_wr_data (i_move_data),
    .i_rd_en   (i_move_from_xlat_buffer),
    .i_rd_sel  (i_move_sel[SEL_BITS-1:0]),
    .o_rd_data (o_move_rdata),
    .o_rd_done (o_move_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // instruction cache flush sequencing

  always @* begin
    next_state = state;
    next_flush = 1'b0;
    case (state)
      ST_IDLE: begin
        if (i_return_and_flush_instr) begin
          next_state = ST_WAIT_IRET;
        end else if (i_cache_flush_instr) begin
          next_state = ST_WAIT_BOUND;
        end
      end
      ST_WAIT_BOUND: begin
        // a new flush request while waiting merges into this one
        if (i_branch_ok || i_block_boundary) begin
          next_flush = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_WAIT_IRET: begin
        if (i_iret_exec) begin
          next_flush = 1'b1;
          next_state = ST_IDLE;
        end else if (i_cache_flush_instr) begin
          // an immediate flush overtakes the deferred one
          next_state = ST_WAIT_BOUND;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // request arriving in the completing cycle is kept, not lost
    if (next_flush && i_return_and_flush_instr) begin
      next_state = ST_WAIT_IRET;
    end else if (next_flush && i_cache_flush_instr) begin
      next_state = ST_WAIT_BOUND;
    end
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state              <= ST_IDLE;
      o_icache_flush_all <= 1'b0;
    end else begin
      state              <= next_state;
      o_icache_flush_all <= next_flush;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // lookup mode, space tags and forced misses

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_icache_lookup_virtual <= 1'b0;
      o_icache_force_miss     <= 1'b0;
      o_icache_tag_virtual    <= 1'b0;
      o_icache_tag_super      <= 1'b0;
    end else begin
      o_icache_lookup_virtual <= i_instr_xlat_en;
      o_icache_tag_virtual    <= i_instr_xlat_en;
      o_icache_tag_super      <= i_fetch_super;
      // disable only masks hits; stored valid state is untouched
      o_icache_force_miss <= i_icache_disable_bit |
                             (lookup_miss & i_xlat_instr &
                              i_xlat_branch_or_newpage);
    end
  end

endmodule // tlbm_miss_reload

`default_nettype wire

/* verif/tlbm_miss_reload_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module tlbm_miss_reload_chk (
  // clock, reset and one-bit signals
  input wire logic        i_clock, i_rst_n, i_xlat_valid, i_xlat_instr, i_xlat_super,
  input wire logic        i_xlat_hit, i_xlat_prot_viol, i_xlat_branch_or_newpage, i_spr_rd,
  input wire logic        i_cache_flush_instr, i_return_and_flush_instr, i_iret_exec,
  input wire logic        i_branch_ok, i_block_boundary, i_icache_disable_bit,
  input wire logic        i_instr_xlat_en, i_fetch_super, o_trap, o_pc1_load, o_chan_load,
  input wire logic        o_spr_hit, o_icache_flush_all, o_icache_lookup_virtual,
  input wire logic        o_icache_force_miss, o_icache_tag_super,
  // buses
  input wire logic [7:0]  i_spr_num, o_trap_vector,
  input wire logic [31:0] i_xlat_addr, o_pc1_addr, o_chan_addr, o_spr_rdata
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire miss = i_xlat_valid && !i_xlat_hit;
  sequence s_flush_req; i_cache_flush_instr ##1 (i_branch_ok || i_block_boundary); endsequence
  sequence s_ret_req; i_return_and_flush_instr ##1 i_iret_exec; endsequence
  property p_trap; 1 |=> o_trap == $past(miss || i_xlat_valid && i_xlat_prot_viol); endproperty
  property p_miss_vec;
    miss |=> o_trap_vector == 8'h08 + {$past(i_xlat_super), !$past(i_xlat_instr)};
  endproperty
  property p_prot_vec;
    i_xlat_valid && i_xlat_hit && i_xlat_prot_viol |=>
      o_trap_vector == ($past(i_xlat_instr) ? 8'h0c : 8'h0d);
  endproperty
  property p_pc1; miss && i_xlat_instr |=> o_pc1_load && o_pc1_addr == $past(i_xlat_addr);
  endproperty
  property p_chan;
    miss && !i_xlat_instr |=> o_chan_load && !o_pc1_load && o_chan_addr == $past(i_xlat_addr);
  endproperty
  property p_spr;
    i_spr_rd |=> o_spr_hit == ($past(i_spr_num) == 8'h0e) && o_spr_rdata[0] == 1'b0
      && o_spr_rdata[31:7] == 25'h0;
  endproperty
  property p_flush; s_flush_req |=> o_icache_flush_all; endproperty
  property p_ret; s_ret_req |=> o_icache_flush_all; endproperty
  property p_force;
    i_icache_disable_bit || miss && i_xlat_instr && i_xlat_branch_or_newpage |=> o_icache_force_miss;
  endproperty
  property p_copy;
    1 |=> o_icache_lookup_virtual == $past(i_instr_xlat_en) && o_icache_tag_super == $past(i_fetch_super);
  endproperty
  a_trap: assert property (p_trap) else $error("trap pulse wrong");
  a_miss_vec: assert property (p_miss_vec) else $error("miss vector wrong");
  a_prot_vec: assert property (p_prot_vec) else $error("protection vector wrong");
  a_pc1: assert property (p_pc1) else $error("fetch address wrong");
  a_chan: assert property (p_chan) else $error("data address wrong");
  a_spr: assert property (p_spr) else $error("hint read wrong");
  a_flush: assert property (p_flush) else $error("flush missing");
  a_ret: assert property (p_ret) else $error("deferred flush missing");
  a_force: assert property (p_force) else $error("force miss missing");
  a_copy: assert property (p_copy) else $error("lookup mode wrong");
endmodule // tlbm_miss_reload_chk
bind tlbm_miss_reload tlbm_miss_reload_chk u_chk (.*);
`default_nettype wire

/* verif/tlbm_trap_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// trap logic side: counts taken traps and flushes, never stalls
module tlbm_trap_sink (
  input  wire logic       i_clock, i_rst_n, o_trap, o_icache_flush_all,
  output var  logic [7:0] o_trap_count, o_flush_count
);
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_trap_count <= 8'h00;
      o_flush_count <= 8'h00;
    end else begin
      o_trap_count <= o_trap_count + {7'h00, o_trap};
      o_flush_count <= o_flush_count + {7'h00, o_icache_flush_all};
    end
  end
endmodule // tlbm_trap_sink
`default_nettype wire

/* verif/tlbm_miss_reload_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module tlbm_miss_reload_bench;
  logic        i_clock = 1'b0, i_rst_n = 1'b0;
  logic        i_xlat_valid, i_xlat_instr, i_xlat_super, i_xlat_hit, i_xlat_hit_way;
  logic        i_xlat_prot_viol, i_xlat_branch_or_newpage, i_spr_rd, i_move_to_xlat_buffer;
  logic        i_move_from_xlat_buffer, i_cache_flush_instr, i_return_and_flush_instr;
  logic        i_iret_exec, i_branch_ok, i_block_boundary, i_icache_disable_bit;
  logic        i_instr_xlat_en, i_fetch_super, o_trap, o_pc1_load, o_chan_load, o_spr_hit;
  logic        o_move_done, o_icache_flush_all, o_icache_lookup_virtual, o_icache_force_miss;
  logic        o_icache_tag_virtual, o_icache_tag_super;
  logic [4:0]  i_xlat_set;
  logic [7:0]  i_spr_num, o_trap_vector, o_trap_count, o_flush_count;
  logic [31:0] i_xlat_addr, i_move_sel, i_move_data, o_pc1_addr, o_chan_addr;
  logic [31:0] o_spr_rdata, o_move_rdata;
  int          num_errors = 0, checks_done = 0;
  tlbm_miss_reload dut (.*);
  tlbm_trap_sink u_sink (.*);
  always #2 i_clock = ~i_clock;
  task automatic step; @(posedge i_clock); #1; endtask
  // strobes are pulses: drop them all after every request cycle
  task automatic quiet;
    {i_xlat_valid, i_spr_rd, i_move_to_xlat_buffer, i_move_from_xlat_buffer, i_iret_exec,
     i_cache_flush_instr, i_return_and_flush_instr, i_branch_ok, i_block_boundary} = '0;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xlat(input logic [5:0] f, input logic [4:0] set, input logic [31:0] a);
    {i_xlat_instr, i_xlat_super, i_xlat_hit, i_xlat_hit_way, i_xlat_prot_viol} = f[5:1];
    i_xlat_branch_or_newpage = f[0];
    i_xlat_set = set;
    i_xlat_addr = a;
    i_xlat_valid = 1'b1;
    step;
    quiet;
  endtask
  task automatic rd_hint(input logic [7:0] num, input logic [31:0] exp);
    i_spr_rd = 1'b1;
    i_spr_num = num;
    step;
    quiet;
    chk(o_spr_rdata, exp);
  endtask
  task automatic mv(input logic wr, input logic [31:0] sel, d);
    {i_move_to_xlat_buffer, i_move_from_xlat_buffer} = {wr, !wr};
    i_move_sel = sel;
    i_move_data = d;
    step;
    quiet;
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    quiet;
    {i_xlat_instr, i_xlat_super, i_xlat_hit, i_xlat_hit_way, i_xlat_prot_viol} = '0;
    {i_xlat_branch_or_newpage, i_icache_disable_bit, i_instr_xlat_en, i_fetch_super} = '0;
    {i_xlat_set, i_spr_num, i_xlat_addr, i_move_sel, i_move_data} = '0;
    repeat (20) @(posedge i_clock);
    #1 i_rst_n = 1'b1;
    rd_hint(8'h0e, 32'h0);
    chk(o_spr_hit, 1'b1);
    rd_hint(8'h0d, 32'h0);
    for (int k = 0; k < 4; k++) begin
      xlat({!k[0], k[1], 4'h0}, 5'(k + 3), 32'h8000_0000 + k);
      chk(o_trap, 1'b1);
      chk(o_trap_vector, 8'h08 + k);
      chk(k[0] ? o_chan_addr : o_pc1_addr, 32'h8000_0000 + k);
      rd_hint(8'h0e, (k + 3) << 1);
    end
    xlat(6'b001000, 5'd5, 32'h0);
    chk(o_trap, 1'b0);
    xlat(6'b000000, 5'd5, 32'h1234);
    rd_hint(8'h0e, 32'h4a);
    for (int k = 0; k < 2; k++) begin
      xlat({k[0], 5'b11010}, 5'd9, 32'h0);
      chk(o_trap_vector, k ? 8'h0c : 8'h0d);
    end
    rd_hint(8'h0e, 32'h12);
    mv(1'b1, 32'hffff_ffc5, 32'hcafe_0001);
    mv(1'b1, 32'h44, 32'h0bad_0002);
    mv(1'b0, 32'h45, 32'h0);
    chk(o_move_done, 1'b1);
    chk(o_move_rdata, 32'hcafe_0001);
    mv(1'b0, 32'hff44, 32'h0);
    chk(o_move_rdata, 32'h0bad_0002);
    {i_cache_flush_instr, i_branch_ok} = 2'b11;
    step;
    quiet;
    i_block_boundary = 1'b1;
    step;
    quiet;
    chk(o_icache_flush_all, 1'b1);
    step;
    chk(o_icache_flush_all, 1'b0);
    i_return_and_flush_instr = 1'b1;
    step;
    quiet;
    i_branch_ok = 1'b1;
    step;
    quiet;
    i_iret_exec = 1'b1;
    step;
    quiet;
    chk(o_icache_flush_all, 1'b1);
    step;
    chk(o_icache_flush_all, 1'b0);
    {i_icache_disable_bit, i_instr_xlat_en, i_fetch_super} = 3'b111;
    step;
    chk({o_icache_force_miss, o_icache_lookup_virtual}, 2'b11);
    chk({o_icache_tag_virtual, o_icache_tag_super}, 2'b11);
    {i_icache_disable_bit, i_instr_xlat_en, i_fetch_super} = 3'b000;
    step;
    chk({o_icache_force_miss, o_icache_lookup_virtual}, 2'b00);
    xlat(6'b100001, 5'd1, 32'h40);
    chk(o_icache_force_miss, 1'b1);
    step;
    chk({o_trap_count, o_flush_count}, {8'd8, 8'd2});
    report_and_stop;
  end
  // the whole sequence needs about 50 cycles
  initial begin
    #5000;
    num_errors++;
    report_and_stop;
  end
endmodule // tlbm_miss_reload_bench
`default_nettype wire
